/* File: nvm_pkg.sv */
package nvm_pkg;
    // ----------------------------------------------------------------
    // clock and cycle timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ            = 40;
    localparam int ERASE_FAST_TIME_US = 3700;
    localparam int WRITE_FAST_TIME_US = 3000;
    localparam int ERASE_SLOW_TIME_US = 1900;
    localparam int WRITE_SLOW_TIME_US = 1600;
    localparam int ERASE_FAST_CYCLES  = ERASE_FAST_TIME_US * CLK_MHZ;
    localparam int WRITE_FAST_CYCLES  = WRITE_FAST_TIME_US * CLK_MHZ;
    localparam int ERASE_SLOW_CYCLES  = ERASE_SLOW_TIME_US * CLK_MHZ;
    localparam int WRITE_SLOW_CYCLES  = WRITE_SLOW_TIME_US * CLK_MHZ;
    localparam int READ_CYCLES        = 4;
    localparam int CNT_W              = 20;
    localparam int NVM_DEPTH          = 512;
    localparam int NVM_AW             = 9;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_LOW_OFS  = 8'h20;
    localparam logic [7:0] ADDR_HIGH_OFS = 8'h21;
    localparam logic [7:0] DATA_OFS      = 8'h22;
    localparam logic [7:0] CTRL_OFS      = 8'h40;
    localparam logic       SECTOR_0      = 1'b0;
    localparam logic       SECTOR_1      = 1'b1;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    localparam int CTRL_TIMING     = 7;
    localparam int CTRL_ERASE_EN   = 6;
    localparam int CTRL_ERASE_TRIG = 5;
    localparam int CTRL_MODE       = 4;
    localparam int CTRL_WRITE_EN   = 3;
    localparam int CTRL_WRITE_TRIG = 2;
    localparam int CTRL_READ_EN    = 1;
    localparam int CTRL_READ_TRIG  = 0;

    typedef enum logic [1:0] {
        OP_ERASE,
        OP_WRITE,
        OP_READ
    } nvm_op_type;
endpackage

/* File: nvm_if.sv */
interface nvm_if #(
    parameter int CW = nvm_pkg::CNT_W,
    parameter int AW = nvm_pkg::NVM_AW
);
    logic                start;
    nvm_pkg::nvm_op_type op;
    logic [AW-1:0]       addr;
    logic [7:0]          wdata;
    logic [CW-1:0]       cycles;
    logic [7:0]          rdata;
    logic                busy;
    logic                done;

    modport ctrl (output start, output op, output addr, output wdata, output cycles,
                  input rdata, input busy, input done);
    modport mem  (input start, input op, input addr, input wdata, input cycles,
                  output rdata, output busy, output done);
endinterface

/* File: nvm_array.sv */
module nvm_array #(
    parameter int DEPTH = nvm_pkg::NVM_DEPTH,
    parameter int CW    = nvm_pkg::CNT_W,
    parameter int AW    = nvm_pkg::NVM_AW
) (
    input wire logic core_clk,
    input wire logic arst_n,
    nvm_if.mem       bus
);
    import nvm_pkg::*;

    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } arr_state_type;

    typedef struct packed {
        arr_state_type st;
        logic [CW-1:0] cnt;
        nvm_op_type    op;
        logic [AW-1:0] addr;
        logic [7:0]    wdata;
        logic [7:0]    rdata;
        logic          busy;
        logic          done;
    } arr_type;

    arr_type    s_q;
    arr_type    s_d;
    logic [7:0] mem_q [DEPTH];
    logic       commit;

    // ----------------------------------------------------------------
    // cycle sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s_d    = s_q;
        commit = 1'b0;
        s_d.done = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (bus.start) begin
                    s_d.st    = ST_BUSY;
                    s_d.cnt   = bus.cycles;
                    s_d.op    = bus.op;
                    s_d.addr  = bus.addr;
                    s_d.wdata = bus.wdata;
                    s_d.busy  = 1'b1;
                end
            end
            ST_BUSY: begin
                if (s_q.cnt <= CW'(1)) begin
                    commit   = 1'b1;
                    s_d.st   = ST_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    if (s_q.op == OP_READ) begin
                        s_d.rdata = mem_q[s_q.addr];
                    end
                end else begin
                    s_d.cnt = s_q.cnt - CW'(1);
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // storage, one byte per cycle
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (commit && s_q.op == OP_ERASE) begin
            mem_q[s_q.addr] <= ERASED_BYTE;
        end else if (commit && s_q.op == OP_WRITE) begin
            mem_q[s_q.addr] <= s_q.wdata;
        end
    end

    assign bus.rdata = s_q.rdata;
    assign bus.busy  = s_q.busy;
    assign bus.done  = s_q.done;
endmodule

/* File: nvm_access.sv */
// Function
// - 512 bytes, 9-bit address, not memory mapped
// - each access moves one byte via data
// - address and data registers directly in sector 0
// - control at sector 1 offset 40H, indirect
// - address low gives bits 7..0, reset zero
// - address high bit 0 gives bit 8
// - address high bits 7..1 read zero
// - data register 8 bits, reset zero
// - erase enable must be high to erase
// - erase enable low inhibits erase
// - erase trigger starts erase, self clears
module nvm_access #(
    parameter int ERASE_FAST_CYCLES = nvm_pkg::ERASE_FAST_CYCLES,
    parameter int WRITE_FAST_CYCLES = nvm_pkg::WRITE_FAST_CYCLES,
    parameter int ERASE_SLOW_CYCLES = nvm_pkg::ERASE_SLOW_CYCLES,
    parameter int WRITE_SLOW_CYCLES = nvm_pkg::WRITE_SLOW_CYCLES,
    parameter int READ_CYCLES       = nvm_pkg::READ_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       sfr_sector,
    input  wire logic       sfr_indirect,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic            nvm_busy
);
    import nvm_pkg::*;

    typedef struct packed {
        logic [7:0] addr_low;
        logic       addr_bit8;
        logic [7:0] data;
        logic [7:0] ctrl;
        logic [7:0] rdata;
        logic       busy;
        logic       start;
        nvm_op_type op;
        logic [CNT_W-1:0] cycles;
    } top_type;

    top_type s_q;
    top_type s_d;

    nvm_if #(.CW(CNT_W), .AW(NVM_AW)) arr_bus ();

    nvm_array #(
        .DEPTH (NVM_DEPTH),
        .CW    (CNT_W),
        .AW    (NVM_AW)
    ) u_array (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .bus      (arr_bus.mem)
    );

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic direct_hit(input logic sec, input logic ind,
                                        input logic [7:0] a, input logic [7:0] ofs);
        direct_hit = (sec == SECTOR_0) && !ind && (a == ofs);
    endfunction

    function automatic logic ctrl_hit(input logic sec, input logic ind,
                                      input logic [7:0] a);
        ctrl_hit = (sec == SECTOR_1) && ind && (a == CTRL_OFS);
    endfunction

    function automatic logic [CNT_W-1:0] cycle_count(input nvm_op_type op, input logic fast);
        case (op)
            OP_ERASE: begin
                cycle_count = fast ? CNT_W'(ERASE_FAST_CYCLES) : CNT_W'(ERASE_SLOW_CYCLES);
            end
            OP_WRITE: begin
                cycle_count = fast ? CNT_W'(WRITE_FAST_CYCLES) : CNT_W'(WRITE_SLOW_CYCLES);
            end
            OP_READ: begin
                cycle_count = CNT_W'(READ_CYCLES);
            end
            default: begin
                cycle_count = CNT_W'(READ_CYCLES);
            end
        endcase
    endfunction

    function automatic logic [7:0] clear_trigger(input logic [7:0] c, input nvm_op_type op);
        clear_trigger = c;
        case (op)
            OP_ERASE: begin
                clear_trigger[CTRL_ERASE_TRIG] = 1'b0;
            end
            OP_WRITE: begin
                clear_trigger[CTRL_WRITE_TRIG] = 1'b0;
            end
            OP_READ: begin
                clear_trigger[CTRL_READ_TRIG] = 1'b0;
            end
            default: begin
                clear_trigger = c;
            end
        endcase
    endfunction

    function automatic logic [7:0] read_mux(input logic lo, input logic hi, input logic dat,
                                            input logic ctl, input top_type s);
        read_mux = RESET_BYTE;
        if (lo) begin
            read_mux = s.addr_low;
        end else if (hi) begin
            read_mux = {7'h00, s.addr_bit8};
        end else if (dat) begin
            read_mux = s.data;
        end else if (ctl) begin
            read_mux = s.ctrl;
        end
    endfunction

    logic hit_low;
    logic hit_high;
    logic hit_data;
    logic hit_ctrl;
    logic [7:0] ctrl_wr;

    always_comb begin
        hit_low  = direct_hit(sfr_sector, sfr_indirect, sfr_addr, ADDR_LOW_OFS);
        hit_high = direct_hit(sfr_sector, sfr_indirect, sfr_addr, ADDR_HIGH_OFS);
        hit_data = direct_hit(sfr_sector, sfr_indirect, sfr_addr, DATA_OFS);
        hit_ctrl = ctrl_hit(sfr_sector, sfr_indirect, sfr_addr);
        ctrl_wr  = sfr_wdata;
    end

    // ----------------------------------------------------------------
    // register file and cycle launch
    // ----------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.start = 1'b0;
        s_d.busy  = arr_bus.busy | s_q.start;

        // finished cycle clears its trigger first, so a same-cycle set wins
        if (arr_bus.done) begin
            s_d.ctrl = clear_trigger(s_q.ctrl, s_q.op);
        end

        if (sfr_wr && hit_low) begin
            s_d.addr_low = sfr_wdata;
        end
        if (sfr_wr && hit_high) begin
            s_d.addr_bit8 = sfr_wdata[0];
        end
        if (sfr_wr && hit_data) begin
            s_d.data = sfr_wdata;
        end
        if (sfr_wr && hit_ctrl) begin
            s_d.ctrl[CTRL_TIMING]   = ctrl_wr[CTRL_TIMING];
            s_d.ctrl[CTRL_ERASE_EN] = ctrl_wr[CTRL_ERASE_EN];
            s_d.ctrl[CTRL_MODE]     = ctrl_wr[CTRL_MODE];
            s_d.ctrl[CTRL_WRITE_EN] = ctrl_wr[CTRL_WRITE_EN];
            s_d.ctrl[CTRL_READ_EN]  = ctrl_wr[CTRL_READ_EN];
            // a trigger sets only while its enable is already high
            if (ctrl_wr[CTRL_ERASE_TRIG] && s_q.ctrl[CTRL_ERASE_EN]) begin
                s_d.ctrl[CTRL_ERASE_TRIG] = 1'b1;
            end
            if (ctrl_wr[CTRL_WRITE_TRIG] && s_q.ctrl[CTRL_WRITE_EN]) begin
                s_d.ctrl[CTRL_WRITE_TRIG] = 1'b1;
            end
            if (ctrl_wr[CTRL_READ_TRIG] && s_q.ctrl[CTRL_READ_EN]) begin
                s_d.ctrl[CTRL_READ_TRIG] = 1'b1;
            end
        end

        // finished read loads the data register over a software write
        if (arr_bus.done && s_q.op == OP_READ) begin
            s_d.data = arr_bus.rdata;
        end

        // launch from stored triggers, erase first
        if (!s_q.busy && !arr_bus.busy && !arr_bus.done && !s_q.start) begin
            if (s_q.ctrl[CTRL_ERASE_TRIG] && s_q.ctrl[CTRL_ERASE_EN]) begin
                s_d.start  = 1'b1;
                s_d.op     = OP_ERASE;
                s_d.cycles = cycle_count(OP_ERASE, s_q.ctrl[CTRL_TIMING]);
            end else if (s_q.ctrl[CTRL_WRITE_TRIG] && s_q.ctrl[CTRL_WRITE_EN]) begin
                s_d.start  = 1'b1;
                s_d.op     = OP_WRITE;
                s_d.cycles = cycle_count(OP_WRITE, s_q.ctrl[CTRL_TIMING]);
            end else if (s_q.ctrl[CTRL_READ_TRIG] && s_q.ctrl[CTRL_READ_EN]) begin
                s_d.start  = 1'b1;
                s_d.op     = OP_READ;
                s_d.cycles = cycle_count(OP_READ, s_q.ctrl[CTRL_TIMING]);
            end
        end
        if (s_d.start) begin
            s_d.busy = 1'b1;
        end

        // read mux, unmapped reads zero
        s_d.rdata = RESET_BYTE;
        if (sfr_rd) begin
            s_d.rdata = read_mux(hit_low, hit_high, hit_data, hit_ctrl, s_q);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // array link and outputs
    // ----------------------------------------------------------------
    assign arr_bus.start  = s_q.start;
    assign arr_bus.op     = s_q.op;
    assign arr_bus.addr   = {s_q.addr_bit8, s_q.addr_low};
    assign arr_bus.wdata  = s_q.data;
    assign arr_bus.cycles = s_q.cycles;
    assign sfr_rdata      = s_q.rdata;
    assign nvm_busy       = s_q.busy;
endmodule

/* File: nvm_access_asserts.sv */
module nvm_access_asserts #(
    parameter int ERASE_FAST_CYCLES = 20
) (
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic       sfr_sector,
    input wire logic       sfr_indirect,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       nvm_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] run_q;
    logic        s0;
    assign s0 = !sfr_sector && !sfr_indirect;
    // ----------------------------------------------------------------
    // busy run length
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            run_q <= '0;
        else
            run_q <= nvm_busy ? run_q + 20'h0_0001 : '0;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_wr(a);
        sfr_wr && s0 && sfr_addr == a && !nvm_busy;
    endsequence
    sequence s_rd(a);
        sfr_rd && !sfr_wr && s0 && sfr_addr == a && !nvm_busy;
    endsequence
    sequence s_gap;
        !sfr_wr && !sfr_rd;
    endsequence
    AST_LOW_BACK: assert property (
        s_wr(8'h20) ##1 s_gap ##1 s_rd(8'h20) |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("address low readback wrong");
    AST_HIGH_BACK: assert property (
        s_wr(8'h21) ##1 s_gap ##1 s_rd(8'h21) |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'h01))
        else $error("address high readback wrong");
    AST_DATA_BACK: assert property (
        s_wr(8'h22) ##1 s_gap ##1 s_rd(8'h22) |=> sfr_rdata == $past(sfr_wdata, 3))
        else $error("data readback wrong");
    AST_HIGH_TOP: assert property (
        sfr_rd && s0 && sfr_addr == 8'h21 |=> sfr_rdata[7:1] == 7'h00)
        else $error("address high top bits not zero");
    AST_RD_IDLE: assert property (
        !sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data without read");
    AST_UNMAPPED: assert property (
        sfr_rd && s0 && (sfr_addr < 8'h20 || sfr_addr > 8'h22) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_PATH: assert property (
        sfr_rd && sfr_sector && !(sfr_indirect && sfr_addr == 8'h40) |=> sfr_rdata == 8'h00)
        else $error("sector one read not zero");
    AST_BUSY_HOLD: assert property (
        $rose(nvm_busy) |-> nvm_busy [*4])
        else $error("busy too short");
    AST_BUSY_MAX: assert property (
        run_q <= ERASE_FAST_CYCLES + 8)
        else $error("busy too long");
endmodule
bind nvm_access nvm_access_asserts #(.ERASE_FAST_CYCLES(ERASE_FAST_CYCLES)) i_nvm_access_asserts (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_sector(sfr_sector),
    .sfr_indirect(sfr_indirect), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .nvm_busy(nvm_busy));

/* File: nvm_access_tb.sv */
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("BAD %0t got %h exp %h", $time, a, e); end end
module nvm_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nvm_pkg::*;
    logic       core_clk;
    logic       arst_n = 0, sfr_sector = 0, sfr_indirect = 0;
    logic       sfr_wr = 0, sfr_rd = 0, pend = 0, nvm_busy;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, al, ah, dt, e;
    logic [7:0] exp_q[$];
    int         err_total = 0;
    int         n_compared = 0;
    nvm_access #(.ERASE_FAST_CYCLES(20), .WRITE_FAST_CYCLES(16), .ERASE_SLOW_CYCLES(12),
        .WRITE_SLOW_CYCLES(10), .READ_CYCLES(4)) i_nvm_access (
        .core_clk(core_clk), .arst_n(arst_n), .sfr_sector(sfr_sector),
        .sfr_indirect(sfr_indirect), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .nvm_busy(nvm_busy));
    initial begin
        core_clk = 0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ----------------------------------------------------------------
    // read result monitor
    // ----------------------------------------------------------------
    always @(posedge core_clk) pend <= sfr_rd;
    always @(negedge core_clk) begin
        if (pend) begin
            e = exp_q.pop_front();
            `CHK(sfr_rdata, e)
        end
    end
    task report_and_stop;
        $display("errors %0d compared %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task wr(input logic s, input logic i, input logic [7:0] a, input logic [7:0] d);
        sfr_sector = s;
        sfr_indirect = i;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        @(negedge core_clk);
        sfr_wr = 0;
        @(negedge core_clk);
    endtask
    task rd(input logic s, input logic i, input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        sfr_sector = s;
        sfr_indirect = i;
        sfr_addr = a;
        sfr_rd = 1;
        @(negedge core_clk);
        sfr_rd = 0;
        @(negedge core_clk);
    endtask
    task op(input logic [7:0] en, input logic [7:0] tr, input int n);
        int k;
        wr(1, 1, 8'h40, en);
        wr(1, 1, 8'h40, tr);
        k = 0;
        while (nvm_busy !== 1'b1 && k < 50) begin
            @(negedge core_clk);
            k++;
        end
        k = 0;
        while (nvm_busy === 1'b1 && k < 999) begin
            @(negedge core_clk);
            k++;
        end
        `CHK(k >= n && k <= n + 4, 1'b1)
        repeat (2) @(negedge core_clk);
        rd(1, 1, 8'h40, en);
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(7610));
        repeat (6) @(negedge core_clk);
        arst_n = 1;
        rd(0, 0, 8'h20, 8'h00);
        rd(0, 0, 8'h21, 8'h00);
        rd(0, 0, 8'h22, 8'h00);
        rd(1, 1, 8'h40, 8'h00);
        repeat (8) begin
            al = 8'($urandom);
            ah = 8'($urandom);
            dt = 8'($urandom);
            wr(0, 0, 8'h20, al);
            rd(0, 0, 8'h20, al);
            wr(0, 0, 8'h21, ah);
            rd(0, 0, 8'h21, ah & 8'h01);
            wr(0, 0, 8'h22, dt);
            rd(0, 0, 8'h22, dt);
        end
        wr(1, 0, 8'h40, 8'hFF);
        wr(0, 1, 8'h20, 8'h00);
        rd(0, 0, 8'h20, al);
        rd(1, 1, 8'h40, 8'h00);
        rd(0, 0, 8'h23, 8'h00);
        rd(1, 1, 8'h41, 8'h00);
        wr(0, 0, 8'h20, 8'hA5);
        wr(0, 0, 8'h21, 8'h01);
        wr(0, 0, 8'h22, 8'h5C);
        wr(1, 1, 8'h40, 8'h0C);
        rd(1, 1, 8'h40, 8'h08);
        op(8'h88, 8'h8C, 16);
        wr(0, 0, 8'h22, 8'h00);
        op(8'h02, 8'h03, 4);
        rd(0, 0, 8'h22, 8'h5C);
        wr(1, 1, 8'h40, 8'h00);
        wr(1, 1, 8'h40, 8'h20);
        repeat (8) begin
            @(negedge core_clk);
            `CHK(nvm_busy, 1'b0)
        end
        rd(1, 1, 8'h40, 8'h00);
        op(8'hC0, 8'hE0, 20);
        op(8'h02, 8'h03, 4);
        rd(0, 0, 8'h22, 8'hFF);
        wr(0, 0, 8'h22, 8'h3C);
        op(8'h08, 8'h0C, 10);
        op(8'h02, 8'h03, 4);
        rd(0, 0, 8'h22, 8'h3C);
        repeat (2) @(negedge core_clk);
        report_and_stop;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        report_and_stop;
    end
endmodule
